// ---- headphone_amp_i2c_control.sv ----
// two-wire write-only control port with gain mapping and shutdown timing
// assumes an external master; the serial clock is also the link clock
// Contract
// - answer only to address byte 11101100, sent msb first
// - data byte: gain code bits 7..3, mute bit 2, left 1, right 0
// - gain code maps to 32 steps, -76 dB through +18 dB
// - data falling while clock high starts a transfer
// - every address and data bit sampled on rising serial clock
// - matching address gets data line held low for whole ack pulse
// - every data byte after a matching address gets an acknowledge slot with data held low
// - further data bytes each accepted and acknowledged
// - data rising while clock high ends the transfer
// - both enables zero means shutdown, outputs high impedance
// - leaving shutdown waits 400 us before outputs operational
`timescale 1ns/1ps
module headphone_amp_i2c_control (
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic                 serial_clk,
   input  wire logic                 serial_data_in,
   output logic                      serial_data_out,
   output logic                      serial_data_oe,
   output hp_amp_pkg::control_s      control,
   output logic signed [7:0]         gain_db,
   output logic                      left_active,
   output logic                      right_active,
   output logic                      shutdown,
   output logic                      outputs_ready
);
   import hp_amp_pkg::*;

   typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_DATA, ST_DATA_ACK,
                 ST_IGNORE} link_state_e;

   // gain table lookup
   function automatic logic signed [7:0] gain_of(input logic [4:0] code);
      logic signed [7:0] g;
      g = 8'sh00;
      unique case (code)
         5'h00: g = -8'sd76;  5'h01: g = -8'sd62;
         5'h02: g = -8'sd52;  5'h03: g = -8'sd44;
         5'h04: g = -8'sd38;  5'h05: g = -8'sd34;
         5'h06: g = -8'sd30;  5'h07: g = -8'sd27;
         5'h08: g = -8'sd24;  5'h09: g = -8'sd21;
         5'h0A: g = -8'sd18;  5'h0B: g = -8'sd16;
         5'h0C: g = -8'sd14;  5'h0D: g = -8'sd12;
         5'h0E: g = -8'sd10;  5'h0F: g = -8'sd8;
         5'h10: g = -8'sd6;   5'h11: g = -8'sd4;
         5'h12: g = -8'sd2;   5'h13: g = 8'sd0;
         5'h14: g = 8'sd2;    5'h15: g = 8'sd4;
         5'h16: g = 8'sd6;    5'h17: g = 8'sd8;
         5'h18: g = 8'sd10;   5'h19: g = 8'sd12;
         5'h1A: g = 8'sd13;   5'h1B: g = 8'sd14;
         5'h1C: g = 8'sd15;   5'h1D: g = 8'sd16;
         5'h1E: g = 8'sd17;   5'h1F: g = 8'sd18;
      endcase
      return g;
   endfunction : gain_of

   // ---------------- link domain (serial clock) ----------------
   link_state_e state;
   logic [2:0]  bit_count;
   logic [7:0]  shift;
   logic [7:0]  rx_byte;
   logic        rx_toggle;
   logic        start_seen;
   logic        stop_seen;
   logic        start_ack;
   logic        stop_ack;
   logic [7:0]  next_shift;

   assign next_shift = {shift[6:0], serial_data_in};

   // start and stop are edges of data while clock high; the flags live in
   // the data-edge domain and are cleared by rising clock acknowledgement
   always_ff @(negedge serial_data_in or negedge resetn) begin
      if (!resetn) begin
         start_seen <= 1'b0;
      end else if (serial_clk) begin
         start_seen <= ~start_ack;
      end
   end

   always_ff @(posedge serial_data_in or negedge resetn) begin
      if (!resetn) begin
         stop_seen <= 1'b0;
      end else if (serial_clk) begin
         stop_seen <= ~stop_ack;
      end
   end

   logic start_pending;
   logic stop_pending;
   assign start_pending = start_seen ^ start_ack;
   assign stop_pending  = stop_seen ^ stop_ack;

   always_ff @(posedge serial_clk or negedge resetn) begin
      if (!resetn) begin
         start_ack <= 1'b0;
         stop_ack  <= 1'b0;
      end else begin
         start_ack <= start_seen;
         stop_ack  <= stop_seen;
      end
   end

   // bit engine: all sampling on the rising serial clock
   always_ff @(posedge serial_clk or negedge resetn) begin
      if (!resetn) begin
         state     <= ST_IDLE;
         bit_count <= 3'h0;
         shift     <= 8'h00;
         rx_byte   <= CONTROL_RESET;
         rx_toggle <= 1'b0;
      end else if (start_pending) begin
         // first address bit is taken on this edge
         state     <= ST_ADDR;
         shift     <= {7'h00, serial_data_in};
         bit_count <= 3'h1;
      end else if (stop_pending) begin
         state     <= ST_IDLE; // partial byte discarded
         bit_count <= 3'h0;
      end else begin
         unique case (state)
            ST_IDLE, ST_IGNORE: begin
               bit_count <= 3'h0;
            end
            ST_ADDR: begin
               shift     <= next_shift;
               bit_count <= bit_count + 3'h1;
               if (bit_count == 3'h7) begin
                  state <= (next_shift == DEVICE_ADDRESS) ?
                           ST_ADDR_ACK : ST_IGNORE;
               end
            end
            ST_ADDR_ACK: begin
               state     <= ST_DATA;
               bit_count <= 3'h0;
            end
            ST_DATA: begin
               shift     <= next_shift;
               bit_count <= bit_count + 3'h1;
               if (bit_count == 3'h7) begin
                  state <= ST_DATA_ACK;
               end
            end
            ST_DATA_ACK: begin
               // byte commits at the rising edge of its ack pulse
               rx_byte   <= shift;
               rx_toggle <= ~rx_toggle;
               state     <= ST_DATA;
               bit_count <= 3'h0;
            end
         endcase
      end
   end

   // ack drive changes on falling clock so it covers the whole high phase
   logic ack_drive;
   always_ff @(negedge serial_clk or negedge resetn) begin
      if (!resetn) begin
         ack_drive <= 1'b0;
      end else begin
         ack_drive <= (state == ST_ADDR_ACK) ||
                      (state == ST_DATA_ACK);
      end
   end

   assign serial_data_out = 1'b0;
   // registered only: gating by state would release the line at the
   // rising edge of the ack pulse, which would also look like a stop
   assign serial_data_oe  = ack_drive;

   // ---------------- system domain (clk) ----------------
   logic [2:0] toggle_sync;
   logic [7:0] byte_hold;
   logic       byte_event;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         toggle_sync <= 3'b000;
      end else begin
         toggle_sync <= {toggle_sync[1:0], rx_toggle};
      end
   end
   assign byte_event = toggle_sync[2] ^ toggle_sync[1];

   // rx_byte is stable for many clk cycles after the toggle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         byte_hold <= CONTROL_RESET;
      end else if (byte_event) begin
         byte_hold <= rx_byte;
      end
   end

   always_comb begin
      control.gain_code        = byte_hold[GAIN_MSB:GAIN_LSB];
      control.mute             = byte_hold[MUTE_BIT];
      control.left_channel_on  = byte_hold[LEFT_ON_BIT];
      control.right_channel_on = byte_hold[RIGHT_ON_BIT];
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gain_db <= gain_of(GAIN_MIN_CODE);
      end else if (control.mute) begin
         gain_db <= gain_of(GAIN_MIN_CODE);
      end else begin
         gain_db <= gain_of(control.gain_code);
      end
   end

   logic                         next_shutdown;
   logic [$clog2(PUMP_WAKEUP_CYCLES+1)-1:0] wake_count;

   assign next_shutdown = ~control.left_channel_on &
                          ~control.right_channel_on;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shutdown <= 1'b1;
      end else begin
         shutdown <= next_shutdown;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wake_count <= '0;
      end else if (shutdown) begin
         wake_count <= '0;
      end else if (wake_count !=
                   $bits(wake_count)'(PUMP_WAKEUP_CYCLES)) begin
         wake_count <= wake_count + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         outputs_ready <= 1'b0;
         left_active   <= 1'b0;
         right_active  <= 1'b0;
      end else begin
         // drops in the same cycle as shutdown rises
         outputs_ready <= !next_shutdown && wake_count ==
                          $bits(wake_count)'(PUMP_WAKEUP_CYCLES);
         left_active   <= control.left_channel_on;
         right_active  <= control.right_channel_on;
      end
   end

   a_ack_on_match: assert property (
      @(posedge serial_clk) disable iff (!resetn)
      (state == ST_ADDR && bit_count == 3'h7 && !start_pending
      && !stop_pending && next_shift == DEVICE_ADDRESS) |=>
      state == ST_ADDR_ACK)
      else $error("matching address not acknowledged");

   a_no_ack_miss: assert property (
      @(posedge serial_clk) disable iff (!resetn)
      state == ST_IGNORE |-> !serial_data_oe)
      else $error("data line driven for foreign address");

   a_ack_held: assert property (
      @(posedge serial_clk) disable iff (!resetn)
      (state == ST_ADDR_ACK || state == ST_DATA_ACK) |-> serial_data_oe)
      else $error("acknowledge not held at clock rise");

   a_mute_min: assert property (
      @(posedge clk) disable iff (!resetn)
      control.mute |=> gain_db == -8'sd76)
      else $error("mute did not force minimum gain");

   a_shutdown_ready: assert property (
      @(posedge clk) disable iff (!resetn)
      shutdown |-> !outputs_ready)
      else $error("outputs ready during shutdown");

   a_wake_delay: assert property (
      @(posedge clk) disable iff (!resetn)
      $rose(outputs_ready) |-> $past(wake_count) ==
      $bits(wake_count)'(PUMP_WAKEUP_CYCLES))
      else $error("outputs ready before wake-up interval");

   a_shutdown_bits: assert property (
      @(posedge clk) disable iff (!resetn)
      next_shutdown |=> shutdown)
      else $error("shutdown not entered");

   a_commit_ack: assert property (
      @(posedge serial_clk) disable iff (!resetn)
      $changed(rx_toggle) |-> $past(state) == ST_DATA_ACK)
      else $error("byte committed outside acknowledge");

   a_gain_top: assert property (
      @(posedge clk) disable iff (!resetn)
      (!control.mute && control.gain_code == 5'h1F) |=> gain_db == 8'sd18)
      else $error("top gain code wrong");

endmodule : headphone_amp_i2c_control

// ---- hp_amp_master_model.sv ----
// two-wire bus master model for the amplifier control port
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
module hp_amp_master_model (
   output logic      serial_clk,
   output logic      sda_drive,
   input  wire logic sda_line
);
   localparam int QTR = 8;  // quarter of a 32 ns serial clock period

   initial begin
      serial_clk = 1'b1;  // clock stands still high outside frames
      sda_drive  = 1'b1;
   end

   task automatic frame_start;
      sda_drive = 1'b0;
      #(2*QTR) serial_clk = 1'b0;
      #QTR;
   endtask : frame_start

   task automatic frame_stop;
      sda_drive = 1'b0;
      #QTR serial_clk = 1'b1;
      #(2*QTR) sda_drive = 1'b1;
      #(2*QTR);
   endtask : frame_stop

   // top n bits msb first; an acknowledge slot only for a whole byte
   task automatic send(input logic [7:0] b, input int n, output logic ack);
      ack = 1'b0;
      for (int i = 7; i > 7 - n; i--) begin
         sda_drive = b[i];
         #QTR serial_clk = 1'b1;
         #(2*QTR) serial_clk = 1'b0;
         #QTR;
      end
      if (n == 8) begin
         sda_drive = 1'b1;
         #QTR serial_clk = 1'b1;
         #QTR ack = !sda_line;
         #QTR serial_clk = 1'b0;
         #QTR;
      end
   endtask : send
endmodule : hp_amp_master_model

// ---- hp_amp_pkg.sv ----
// package for the headphone amplifier two-wire control port
// assumes a 125 MHz system clock; the link side runs on the serial clock
package hp_amp_pkg;

   localparam logic [7:0] DEVICE_ADDRESS = 8'hEC;
   localparam int         BYTE_BITS      = 8;

   // control byte field positions
   localparam int GAIN_MSB       = 7;
   localparam int GAIN_LSB       = 3;
   localparam int MUTE_BIT       = 2;
   localparam int LEFT_ON_BIT    = 1;
   localparam int RIGHT_ON_BIT   = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [4:0] GAIN_MIN_CODE = 5'h00;

   // charge pump wake-up interval
   localparam int CLK_PERIOD_NS          = 8;
   localparam int PUMP_WAKEUP_US         = 400;
   localparam int PUMP_WAKEUP_CYCLES     =
      (PUMP_WAKEUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic [4:0] gain_code;
      logic       mute;
      logic       left_channel_on;
      logic       right_channel_on;
   } control_s;

endpackage : hp_amp_pkg

// ---- tb_top.sv ----
// self-checking bench for the amplifier two-wire control port
// assumes hp_amp_pkg and the master model are compiled first
`timescale 1ns/1ps
module tb_top;
   import hp_amp_pkg::*;
   logic              clk = 1'b0;
   logic              resetn = 1'b0;
   logic              serial_clk, sda_drive, sda_line;
   logic              serial_data_out, serial_data_oe;
   control_s          control;
   logic signed [7:0] gain_db;
   logic              left_active, right_active, shutdown, outputs_ready;
   logic [7:0]        exp_q[$];
   logic [7:0]        last_byte = CONTROL_RESET;
   logic [31:0]       lfsr = 32'hFB9FF7E1;
   int                miscompares = 0;
   int                check_count = 0;
   int gain_tbl[32] = '{-76,-62,-52,-44,-38,-34,-30,-27,-24,-21,-18,-16,
      -14,-12,-10,-8,-6,-4,-2,0,2,4,6,8,10,12,13,14,15,16,17,18};

   always #4 clk = ~clk;
   assign sda_line = (serial_data_oe && !serial_data_out) ? 1'b0 : sda_drive;

   hp_amp_master_model master_u (.serial_clk(serial_clk),
      .sda_drive(sda_drive), .sda_line(sda_line));
   headphone_amp_i2c_control dut_u (.clk(clk), .resetn(resetn),
      .serial_clk(serial_clk), .serial_data_in(sda_line),
      .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
      .control(control), .gain_db(gain_db), .left_active(left_active),
      .right_active(right_active), .shutdown(shutdown),
      .outputs_ready(outputs_ready));

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
   endfunction : lfsr_next

   task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask : cmp8

   task automatic cmp1(input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask : cmp1

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   // notes each changed byte as expected before it goes out
   task automatic write_frame(input logic [7:0] addr,
                              input logic [7:0] data[$], input logic ok);
      logic ack;
      master_u.frame_start();
      master_u.send(addr, 8, ack);
      cmp1(ok, ack);
      foreach (data[i]) begin
         if (ok && data[i] !== last_byte) begin
            exp_q.push_back(data[i]);
            last_byte = data[i];
         end
         master_u.send(data[i], 8, ack);
         cmp1(ok, ack);
      end
      master_u.frame_stop();
   endtask : write_frame

   initial begin : monitor
      control_s   seen;
      logic [7:0] e;
      logic [7:0] g;
      seen = CONTROL_RESET;
      forever begin
         @(posedge clk);
         #1;
         if (control !== seen) begin
            seen = control;
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            cmp8(e, control);
            repeat (3) @(posedge clk);
            #1;
            g = 8'(gain_tbl[e[MUTE_BIT] ? GAIN_MIN_CODE : e[7:3]]);
            cmp8(g, gain_db);
            cmp1(e[1:0] == 2'b00, shutdown);
            cmp1(e[LEFT_ON_BIT], left_active);
            cmp1(e[RIGHT_ON_BIT], right_active);
         end
      end
   end

   initial begin : main_seq
      logic [7:0] q[$];
      logic       ack;
      int         n;
      logic       wake_ok;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      cmp8(CONTROL_RESET, control);
      cmp1(1'b1, shutdown);
      $display("test reset done");
      write_frame(DEVICE_ADDRESS ^ 8'h80, '{8'hFF}, 1'b0);
      write_frame(DEVICE_ADDRESS ^ 8'h01, '{8'hFF}, 1'b0);
      $display("test foreign address done");
      for (int c = 0; c < 32; c++) begin
         q.push_back({5'(c), 1'b0, lfsr[1:0]});
         lfsr = lfsr_next(lfsr);
      end
      for (int k = 0; k < 8; k++) begin
         q.push_back(lfsr[7:0]);
         lfsr = lfsr_next(lfsr);
      end
      write_frame(DEVICE_ADDRESS, q, 1'b1);
      $display("test gain codes done");
      master_u.frame_start();
      master_u.send(DEVICE_ADDRESS, 8, ack);
      master_u.send(~last_byte, 4, ack);
      master_u.frame_stop();
      repeat (8) @(posedge clk);
      #1;
      cmp8(last_byte, control);
      $display("test partial byte done");
      write_frame(DEVICE_ADDRESS, '{8'h00, 8'h9B}, 1'b1);
      cmp1(1'b0, outputs_ready);
      n = 0;
      while (n < PUMP_WAKEUP_CYCLES + 20 && outputs_ready !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
      end
      wake_ok = n > PUMP_WAKEUP_CYCLES - 12 && n < PUMP_WAKEUP_CYCLES;
      cmp1(1'b1, wake_ok);
      $display("test wake-up done");
      repeat (10) @(posedge clk);
      cmp8(8'h00, 8'(exp_q.size()));
      finish_test();
   end

   initial begin : watchdog
      // wake-up interval plus ample room for the short frames
      repeat (PUMP_WAKEUP_CYCLES + 10000) @(posedge clk);
      miscompares++;
      finish_test();
   end
endmodule : tb_top
